// >>> rtl/gwp_map.svh
`ifndef GWP_MAP_SVH
`define GWP_MAP_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define GWP_DQ_W 32
`define GWP_COL_W 8
`define GWP_NBANK 4
`define GWP_WL_W 3
`define GWP_RP_W 2

// ----------------------------------------------------------------
// burst and timing
// ----------------------------------------------------------------
`define GWP_BURST_LEN 4
`define GWP_BURST_CYC (`GWP_BURST_LEN / 2)
`define GWP_TCK_NS 10
`define GWP_PRECHARGE_PERIOD_NS 15
`define GWP_PRECHARGE_CYC ((`GWP_PRECHARGE_PERIOD_NS + `GWP_TCK_NS - 1) / `GWP_TCK_NS)
`define GWP_PD_EXIT_CYC 6

// ----------------------------------------------------------------
// command pin codes {ras_b, cas_b, we_b} with cs_b low
// ----------------------------------------------------------------
`define GWP_CODE_NOP 3'h7
`define GWP_CODE_READ 3'h5
`define GWP_CODE_WRITE 3'h4
`define GWP_CODE_PRE 3'h2
`define GWP_CODE_ACT 3'h3
`define GWP_CODE_REF 3'h1
`define GWP_CODE_MRS 3'h0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GWP_BUF_EN_RST 1'b1
`define GWP_DQ_HIZ_RST 1'b1

`endif

// >>> rtl/gwp_pkg.sv
`include "gwp_map.svh"

package gwp_pkg;

    // power-down states, gray along act -> pd -> exit
    typedef enum logic [1:0] {
        GWP_ST_ACT = 2'h0,
        GWP_ST_PD = 2'h1,
        GWP_ST_EXIT = 2'h3
    } gwp_pd_t;

    typedef enum logic [2:0] {
        GWP_C_NOP,
        GWP_C_DESEL,
        GWP_C_READ,
        GWP_C_WRITE,
        GWP_C_PRE,
        GWP_C_ACT,
        GWP_C_REF,
        GWP_C_MRS
    } gwp_cmd_t;

    // link-domain state
    typedef struct packed {
        logic [`GWP_WL_W-1:0] wl_s1;
        logic [`GWP_WL_W-1:0] wl_s2;
        logic cke_prev;
        gwp_pd_t pd;
        logic [2:0] exit_cnt;
        logic act_pd;
        logic buf_en;
        logic dq_hiz;
        logic [`GWP_NBANK-1:0] bank_open;
        logic [`GWP_NBANK-1:0][`GWP_RP_W-1:0] rp_cnt;
        logic wr_busy;
        logic wr_ap;
        logic [1:0] wr_bank;
        logic [`GWP_COL_W-1:0] wr_col;
        logic [`GWP_WL_W-1:0] wl_cnt;
        logic [1:0] burst_cnt;
        logic arm;
    } gwp_link_t;

    // user-domain state
    typedef struct packed {
        logic done_s1;
        logic done_s2;
        logic done_s3;
        logic [`GWP_NBANK-1:0] bopen_s1;
        logic [`GWP_NBANK-1:0] bopen_s2;
        logic pd_s1;
        logic pd_s2;
        logic apd_s1;
        logic apd_s2;
        logic wr_valid;
        logic [4*`GWP_DQ_W-1:0] wr_data;
        logic [1:0] wr_bank;
        logic [`GWP_COL_W-1:0] wr_col;
        logic wr_ap;
    } gwp_sys_t;

    // command decode from the four strobes
    function automatic gwp_cmd_t gwp_decode(input logic cs_b, input logic ras_b,
                                            input logic cas_b, input logic we_b);
        gwp_cmd_t c;
        c = GWP_C_NOP;
        if (cs_b) begin
            c = GWP_C_DESEL;
        end else begin
            case ({ras_b, cas_b, we_b})
                `GWP_CODE_READ: c = GWP_C_READ;
                `GWP_CODE_WRITE: c = GWP_C_WRITE;
                `GWP_CODE_PRE: c = GWP_C_PRE;
                `GWP_CODE_ACT: c = GWP_C_ACT;
                `GWP_CODE_REF: c = GWP_C_REF;
                `GWP_CODE_MRS: c = GWP_C_MRS;
                default: c = GWP_C_NOP;
            endcase
        end
        return c;
    endfunction

endpackage

// >>> rtl/gwp_strobe_capture.sv
`timescale 1ns/1ns

module gwp_strobe_capture
    import gwp_pkg::*;
(
    input wire logic write_data_strobe, // strobe from controller, used as clock
    input wire logic rst_b, // async reset, active low
    input wire logic arm, // burst window from link logic
    input wire logic [`GWP_DQ_W-1:0] dq_in, // data pins
    input wire logic [1:0] bank_in, // bank of current burst
    input wire logic [`GWP_COL_W-1:0] col_in, // column of current burst
    input wire logic ap_in, // auto precharge of current burst
    output logic [4*`GWP_DQ_W-1:0] word, // four elements, element 0 low
    output logic [1:0] cap_bank, // bank latched with element 0
    output logic [`GWP_COL_W-1:0] cap_col, // column latched with element 0
    output logic cap_ap, // auto precharge latched with element 0
    output logic done_tgl // flips once per full burst
);

    logic [1:0] rise_idx;
    logic [`GWP_DQ_W-1:0] e0, e1, e2, e3;

    // ----------------------------------------------------------------
    // rising edges: element 0 opens a burst, element 2 follows
    // ----------------------------------------------------------------
    always_ff @(posedge write_data_strobe or negedge rst_b) begin
        if (!rst_b) begin
            rise_idx <= 2'h0;
            e0 <= '0;
            e2 <= '0;
            cap_bank <= 2'h0;
            cap_col <= '0;
            cap_ap <= 1'b0;
        end else if (rise_idx == 2'h1) begin
            e2 <= dq_in;
            rise_idx <= 2'h2;
        end else if (arm) begin
            e0 <= dq_in; // first element only inside the window
            cap_bank <= bank_in;
            cap_col <= col_in;
            cap_ap <= ap_in;
            rise_idx <= 2'h1;
        end else begin
            rise_idx <= 2'h0; // stray edges drop data
        end
    end

    // ----------------------------------------------------------------
    // falling edges: elements 1 and 3, burst done on 3
    // ----------------------------------------------------------------
    always_ff @(negedge write_data_strobe or negedge rst_b) begin
        if (!rst_b) begin
            e1 <= '0;
            e3 <= '0;
            done_tgl <= 1'b0;
        end else if (rise_idx == 2'h1) begin
            e1 <= dq_in;
        end else if (rise_idx == 2'h2) begin
            e3 <= dq_in;
            done_tgl <= ~done_tgl;
        end
    end

    assign word = {e3, e2, e1, e0};

endmodule

// >>> rtl/gwp_write_pd_core.sv
`timescale 1ns/1ns

// What this block does
// - write starts on command with bank, column, precharge flag
// - auto precharge closes row after burst
// - first element rising strobe after latency, then every edge
// - data pins stay high-impedance, extra data dropped
// - writes any bank, read may follow write; read commands are ignored here
// - precharge: one bank by selects, or all banks
// - bank idle after precharge period, activate before access
// - precharge two clocks after read keeps read burst; reads are decoded but not executed here
// - clock enable low enters active or precharge power-down
// - power-down turns off buffers except clock, enable
// - exit on enable high with nop, commands six later
// - action from enable now, enable before, state, command
// - write code: select low, row high, column low, write low
// - precharge code: select low, row low, column high, write low

module gwp_write_pd_core
    import gwp_pkg::*;
(
    input wire logic clock, // user clock, 100 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic link_clk, // memory clock from controller
    input wire logic cke, // clock enable pin
    input wire logic cs_b, // chip select, active low
    input wire logic ras_b, // row strobe, active low
    input wire logic cas_b, // column strobe, active low
    input wire logic we_b, // write strobe, active low
    input wire logic bank_select_bit0, // bank select low bit
    input wire logic bank_select_bit1, // bank select high bit
    input wire logic all_banks_select_bit, // all banks / auto precharge flag
    input wire logic [`GWP_COL_W-1:0] col_addr, // column address
    input wire logic write_data_strobe, // write strobe from controller
    input wire logic [`GWP_DQ_W-1:0] dq_in, // data pins, input side
    output logic [`GWP_DQ_W-1:0] dq_out, // data pins, output side
    output logic dq_oe_b, // data pin enable, low drives
    output logic input_buf_en, // input buffers on
    input wire logic [`GWP_WL_W-1:0] wr_latency, // programmed write latency
    output logic wr_valid, // one-cycle pulse per received burst
    output logic [4*`GWP_DQ_W-1:0] wr_data, // burst data, element 0 low
    output logic [1:0] wr_bank, // bank of received burst
    output logic [`GWP_COL_W-1:0] wr_col, // column of received burst
    output logic wr_autopre, // burst carried auto precharge
    output logic [`GWP_NBANK-1:0] bank_open_status, // open rows per bank
    output logic power_down, // device in power-down
    output logic active_power_down // power-down with an open row
);

    gwp_link_t l, next_l;
    gwp_sys_t s, next_s;
    gwp_cmd_t cmd;
    logic [1:0] bank;
    logic [4*`GWP_DQ_W-1:0] cap_word;
    logic [1:0] cap_bank;
    logic [`GWP_COL_W-1:0] cap_col;
    logic cap_ap;
    logic cap_done_tgl;
    logic accept;

    // ----------------------------------------------------------------
    // command decode, valid only with enable high at both edges
    // ----------------------------------------------------------------
    assign cmd = gwp_decode(cs_b, ras_b, cas_b, we_b);
    assign bank = {bank_select_bit1, bank_select_bit0};
    assign accept = (l.pd == GWP_ST_ACT) && l.cke_prev && cke;

    // ----------------------------------------------------------------
    // link side: banks, write sequencing, power-down
    // ----------------------------------------------------------------
    always_comb begin
        next_l = l;
        next_l.wl_s1 = wr_latency;
        next_l.wl_s2 = l.wl_s1;
        next_l.cke_prev = cke;
        next_l.dq_hiz = 1'b1; // never drives during writes
        // precharge period countdown, bank idle at zero
        for (int i = 0; i < `GWP_NBANK; i++) begin
            if (l.rp_cnt[i] != '0) begin
                next_l.rp_cnt[i] = l.rp_cnt[i] - `GWP_RP_W'(1);
            end
        end
        // write latency then burst window
        if (l.wl_cnt != '0) begin
            next_l.wl_cnt = l.wl_cnt - `GWP_WL_W'(1);
            if (l.wl_cnt == `GWP_WL_W'(1)) begin
                next_l.arm = 1'b1;
                next_l.burst_cnt = 2'(`GWP_BURST_CYC);
            end
        end else if (l.burst_cnt != 2'h0) begin
            next_l.burst_cnt = l.burst_cnt - 2'h1;
            if (l.burst_cnt == 2'h1) begin
                next_l.arm = 1'b0;
                next_l.wr_busy = 1'b0;
                if (l.wr_ap) begin
                    next_l.bank_open[l.wr_bank] = 1'b0;
                    next_l.rp_cnt[l.wr_bank] = `GWP_RP_W'(`GWP_PRECHARGE_CYC);
                end
            end
        end
        // clock enable state machine
        unique case (l.pd)
            GWP_ST_ACT: begin
                if (l.cke_prev && !cke && (cmd == GWP_C_NOP || cmd == GWP_C_DESEL)) begin
                    next_l.pd = GWP_ST_PD;
                    next_l.act_pd = |l.bank_open;
                end
            end
            GWP_ST_PD: begin
                if (cke && (cmd == GWP_C_NOP || cmd == GWP_C_DESEL)) begin
                    next_l.pd = GWP_ST_EXIT;
                    next_l.exit_cnt = 3'(`GWP_PD_EXIT_CYC - 1);
                end
            end
            GWP_ST_EXIT: begin
                next_l.exit_cnt = l.exit_cnt - 3'h1; // commands ignored here
                if (l.exit_cnt == 3'h1) begin
                    next_l.pd = GWP_ST_ACT;
                    next_l.act_pd = 1'b0;
                end
            end
            default: begin
                next_l.pd = GWP_ST_ACT;
            end
        endcase
        // input buffers off while powered down
        next_l.buf_en = (next_l.pd != GWP_ST_PD);
        // executable commands
        if (accept) begin
            unique case (cmd)
                GWP_C_WRITE: begin
                    if (!l.wr_busy && l.bank_open[bank]) begin // any open bank
                        next_l.wr_busy = 1'b1;
                        next_l.wr_ap = all_banks_select_bit;
                        next_l.wr_bank = bank;
                        next_l.wr_col = col_addr;
                        next_l.wl_cnt = (l.wl_s2 == '0) ? `GWP_WL_W'(1) : l.wl_s2;
                    end
                end
                GWP_C_PRE: begin
                    // write burst runs on regardless
                    if (all_banks_select_bit) begin
                        next_l.bank_open = '0;
                        for (int i = 0; i < `GWP_NBANK; i++) begin
                            next_l.rp_cnt[i] = `GWP_RP_W'(`GWP_PRECHARGE_CYC);
                        end
                    end else begin
                        next_l.bank_open[bank] = 1'b0;
                        next_l.rp_cnt[bank] = `GWP_RP_W'(`GWP_PRECHARGE_CYC);
                    end
                end
                GWP_C_ACT: begin
                    if (l.rp_cnt[bank] == '0) begin
                        next_l.bank_open[bank] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // link register
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            l <= '0;
            l.buf_en <= `GWP_BUF_EN_RST;
            l.dq_hiz <= `GWP_DQ_HIZ_RST;
        end else begin
            l <= next_l;
        end
    end

    // ----------------------------------------------------------------
    // strobe-clocked data capture
    // ----------------------------------------------------------------
    gwp_strobe_capture u_capture (
        .write_data_strobe(write_data_strobe),
        .rst_b(rst_b),
        .arm(l.arm),
        .dq_in(dq_in),
        .bank_in(l.wr_bank),
        .col_in(l.wr_col),
        .ap_in(l.wr_ap),
        .word(cap_word),
        .cap_bank(cap_bank),
        .cap_col(cap_col),
        .cap_ap(cap_ap),
        .done_tgl(cap_done_tgl)
    );

    // ----------------------------------------------------------------
    // user side: toggle handshake for bursts, level syncs for status
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.done_s1 = cap_done_tgl;
        next_s.done_s2 = s.done_s1;
        next_s.done_s3 = s.done_s2;
        next_s.bopen_s1 = l.bank_open;
        next_s.bopen_s2 = s.bopen_s1;
        next_s.pd_s1 = (l.pd == GWP_ST_PD);
        next_s.pd_s2 = s.pd_s1;
        next_s.apd_s1 = l.act_pd;
        next_s.apd_s2 = s.apd_s1;
        next_s.wr_valid = s.done_s2 ^ s.done_s3;
        if (s.done_s2 ^ s.done_s3) begin
            next_s.wr_data = cap_word; // stable until next burst
            next_s.wr_bank = cap_bank;
            next_s.wr_col = cap_col;
            next_s.wr_ap = cap_ap;
        end
    end

    // user register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // outputs
    assign dq_out = '0;
    assign dq_oe_b = l.dq_hiz;
    assign input_buf_en = l.buf_en;
    assign wr_valid = s.wr_valid;
    assign wr_data = s.wr_data;
    assign wr_bank = s.wr_bank;
    assign wr_col = s.wr_col;
    assign wr_autopre = s.wr_ap;
    assign bank_open_status = s.bopen_s2;
    assign power_down = s.pd_s2;
    assign active_power_down = s.apd_s2 & s.pd_s2;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_pd_entry: assert property (@(posedge link_clk) disable iff (!rst_b)
        (l.pd == GWP_ST_ACT && l.cke_prev && !cke && (cmd == GWP_C_NOP || cmd == GWP_C_DESEL))
        |=> (l.pd == GWP_ST_PD && l.act_pd == $past(|l.bank_open)))
        else $error("power-down not entered on enable low");

    a_buf_off: assert property (@(posedge link_clk) disable iff (!rst_b)
        (l.pd == GWP_ST_PD) |-> !input_buf_en)
        else $error("input buffers on during power-down");

    a_pd_exit_wait: assert property (@(posedge link_clk) disable iff (!rst_b)
        (l.pd == GWP_ST_PD && cke && (cmd == GWP_C_NOP || cmd == GWP_C_DESEL))
        |=> (l.pd == GWP_ST_EXIT) [*5] ##1 (l.pd == GWP_ST_ACT))
        else $error("power-down exit not six clocks");

    a_exit_ignore: assert property (@(posedge link_clk) disable iff (!rst_b)
        (l.pd != GWP_ST_ACT && cmd == GWP_C_PRE) |=> (l.bank_open == $past(l.bank_open)))
        else $error("command executed outside active state");

    a_pre_one: assert property (@(posedge link_clk) disable iff (!rst_b)
        (accept && cmd == GWP_C_PRE && !all_banks_select_bit)
        |=> !l.bank_open[$past(bank)] && l.rp_cnt[$past(bank)] == `GWP_RP_W'(`GWP_PRECHARGE_CYC))
        else $error("single bank precharge failed");

    a_pre_all: assert property (@(posedge link_clk) disable iff (!rst_b)
        (accept && cmd == GWP_C_PRE && all_banks_select_bit) |=> (l.bank_open == '0))
        else $error("all bank precharge failed");

    a_act_blocked: assert property (@(posedge link_clk) disable iff (!rst_b)
        (accept && cmd == GWP_C_ACT && l.rp_cnt[bank] != '0 && !l.bank_open[bank])
        |=> !l.bank_open[$past(bank)])
        else $error("activate inside precharge period");

    a_write_start: assert property (@(posedge link_clk) disable iff (!rst_b)
        (accept && cmd == GWP_C_WRITE && !l.wr_busy && l.bank_open[bank])
        |=> l.wr_busy && l.wr_ap == $past(all_banks_select_bit) && l.wr_col == $past(col_addr))
        else $error("write not started");

    a_arm_len: assert property (@(posedge link_clk) disable iff (!rst_b)
        $rose(l.arm) |-> l.arm [*2] ##1 !l.arm)
        else $error("capture window not two clocks");

    a_ap_close: assert property (@(posedge link_clk) disable iff (!rst_b)
        (l.arm && l.burst_cnt == 2'h1 && l.wr_ap) |=> !l.bank_open[$past(l.wr_bank)])
        else $error("auto precharge did not close row");

    a_dq_hiz: assert property (@(posedge link_clk) disable iff (!rst_b)
        dq_oe_b)
        else $error("data pins driven");

    c_pd_cycle: cover property (@(posedge link_clk) disable iff (!rst_b)
        (l.pd == GWP_ST_PD) ##1 (l.pd == GWP_ST_EXIT));
    c_write_ap: cover property (@(posedge link_clk) disable iff (!rst_b)
        l.arm && l.wr_ap);
    c_pre_all: cover property (@(posedge link_clk) disable iff (!rst_b)
        accept && cmd == GWP_C_PRE && all_banks_select_bit);
    c_burst_out: cover property (@(posedge clock) disable iff (!rst_b)
        s.wr_valid);

endmodule

// >>> sim/gwp_ctrl_model.sv
`timescale 1ns/1ns
`include "gwp_map.svh"

module gwp_ctrl_model
    import gwp_pkg::*;
(
    input wire logic link_clk, // memory clock
    output logic cke, // clock enable
    output logic cs_b, // chip select
    output logic ras_b, // row strobe
    output logic cas_b, // column strobe
    output logic we_b, // write strobe
    output logic bank_select_bit0, // bank low bit
    output logic bank_select_bit1, // bank high bit
    output logic all_banks_select_bit, // all banks flag
    output logic [`GWP_COL_W-1:0] col_addr, // column
    output logic write_data_strobe, // data strobe
    output logic [`GWP_DQ_W-1:0] dq_in // write data
);
// ------------------------------
// memory controller model
// ------------------------------
// idle: deselect, strobe parked low
initial begin
    cke = 1'b1;
    cs_b = 1'b1;
    {ras_b, cas_b, we_b} = `GWP_CODE_NOP;
    {bank_select_bit1, bank_select_bit0, all_banks_select_bit} = 3'h0;
    col_addr = 8'h00;
    write_data_strobe = 1'b0;
    dq_in = 32'h0;
end

// one command for one edge, then pins released
task cmd(input logic [2:0] code, input logic [1:0] bank, input logic a8, input logic [7:0] col);
    @(negedge link_clk);
    cs_b = 1'b0;
    {ras_b, cas_b, we_b} = code;
    {bank_select_bit1, bank_select_bit0} = bank;
    all_banks_select_bit = a8;
    col_addr = col;
    @(negedge link_clk);
    cs_b = 1'b1;
    {ras_b, cas_b, we_b} = `GWP_CODE_NOP;
    all_banks_select_bit = ~a8;
    col_addr = ~col;
endtask

task nops(input int n);
    repeat (n) @(negedge link_clk);
endtask

// write with low preamble and postamble around four edges
task wr(input logic [1:0] bank, input logic ap, input logic [7:0] col, input int wl, input logic [127:0] d);
    cmd(`GWP_CODE_WRITE, bank, ap, col);
    repeat (wl) @(posedge link_clk);
    for (int i = 0; i < 4; i++) begin
        #1 dq_in = d[32*i+:32];
        #2 write_data_strobe = ~write_data_strobe;
        #3;
    end
    dq_in = ~dq_in;
    nops(2);
endtask

// clock enable level, clock keeps running
task set_cke(input logic v);
    @(negedge link_clk);
    cke = v;
endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ns
`include "gwp_map.svh"

module tb;
// ------------------------------
// bench for write and power-down
// ------------------------------
localparam logic [127:0] D0 = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
localparam logic [127:0] D1 = 128'hA5A5_A5A5_0F0F_0F0F_F0F0_F0F0_5A5A_5A5A;
logic clock = 1'b0;
logic link_clk = 1'b0;
logic rst_b = 1'b0;
logic cke, cs_b, ras_b, cas_b, we_b, bs0, bs1, a8, strobe;
logic [7:0] col, wr_col;
logic [31:0] dq_in, dq_out;
logic dq_oe_b, buf_en, wr_valid, wr_ap, pd, apd;
logic [127:0] wr_data;
logic [1:0] wr_bank;
logic [3:0] bopen;
logic [2:0] wl = 3'h3;
int mismatches = 0;
int comparisons = 0;
int cycles = 0;
logic [138:0] got[$];

always #5 clock = ~clock;
always #6 link_clk = ~link_clk;

gwp_write_pd_core u_gwp_write_pd_core (.clock(clock), .rst_b(rst_b), .link_clk(link_clk), .cke(cke),
    .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .bank_select_bit0(bs0), .bank_select_bit1(bs1),
    .all_banks_select_bit(a8), .col_addr(col), .write_data_strobe(strobe), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_b(dq_oe_b), .input_buf_en(buf_en), .wr_latency(wl), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_bank(wr_bank), .wr_col(wr_col), .wr_autopre(wr_ap), .bank_open_status(bopen), .power_down(pd),
    .active_power_down(apd));
gwp_ctrl_model u_gwp_ctrl_model (.link_clk(link_clk), .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b),
    .we_b(we_b), .bank_select_bit0(bs0), .bank_select_bit1(bs1), .all_banks_select_bit(a8), .col_addr(col),
    .write_data_strobe(strobe), .dq_in(dq_in));

task check(input logic [138:0] seen, input logic [138:0] exp);
    comparisons++;
    if (seen !== exp) begin
        mismatches++;
        $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
endtask

task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
        $display("Result: passed");
    end else begin
        $display("Result: failed");
    end
    $finish;
endtask

// collect received bursts, cut a hang short
always @(negedge clock) begin
    if (wr_valid === 1'b1) begin
        got.push_back({wr_data, wr_bank, wr_col, wr_ap});
    end
    cycles++;
    if (cycles == 20000) begin
        mismatches++;
        end_of_test();
    end
end

task settle;
    repeat (8) @(negedge clock);
endtask

task t_reset;
    check({dq_oe_b, buf_en, wr_valid, pd, apd, bopen}, {5'h18, 4'h0});
endtask

// two back-to-back writes, second with auto precharge
task t_write;
    u_gwp_ctrl_model.cmd(`GWP_CODE_ACT, 2'h1, 1'b0, 8'h00);
    u_gwp_ctrl_model.cmd(`GWP_CODE_ACT, 2'h3, 1'b0, 8'h00);
    u_gwp_ctrl_model.wr(2'h1, 1'b0, 8'h5A, 3, D0);
    u_gwp_ctrl_model.wr(2'h3, 1'b1, 8'hA5, 3, D1);
    settle();
    check(139'(got.size()), 139'h2);
    check(got[0], {D0, 2'h1, 8'h5A, 1'b0});
    check(got[1], {D1, 2'h3, 8'hA5, 1'b1});
    check(bopen, 4'h2);
    check({dq_oe_b, dq_out}, {1'b1, 32'h0});
    got.delete();
endtask

// single bank, early activate refused, then all banks
task t_pre;
    u_gwp_ctrl_model.cmd(`GWP_CODE_ACT, 2'h0, 1'b0, 8'h00);
    u_gwp_ctrl_model.cmd(`GWP_CODE_ACT, 2'h2, 1'b0, 8'h00);
    settle();
    check(bopen, 4'h7);
    u_gwp_ctrl_model.cmd(`GWP_CODE_PRE, 2'h2, 1'b0, 8'h00);
    u_gwp_ctrl_model.cmd(`GWP_CODE_ACT, 2'h2, 1'b0, 8'h00);
    settle();
    check(bopen, 4'h3);
    u_gwp_ctrl_model.cmd(`GWP_CODE_PRE, 2'h2, 1'b1, 8'h00);
    settle();
    check(bopen, 4'h0);
endtask

// power-down entry, commands ignored inside and before exit ends
task t_pd(input logic open);
    if (open) begin
        u_gwp_ctrl_model.cmd(`GWP_CODE_ACT, 2'h1, 1'b0, 8'h00);
    end
    u_gwp_ctrl_model.set_cke(1'b0);
    settle();
    check({pd, apd, buf_en}, {1'b1, open, 1'b0});
    u_gwp_ctrl_model.cmd(`GWP_CODE_PRE, 2'h0, 1'b1, 8'h00);
    u_gwp_ctrl_model.set_cke(1'b1);
    u_gwp_ctrl_model.nops(2);
    u_gwp_ctrl_model.cmd(`GWP_CODE_PRE, 2'h0, 1'b1, 8'h00);
    settle();
    check({pd, buf_en, bopen}, {1'b0, 1'b1, 2'h0, open, 1'b0});
    u_gwp_ctrl_model.cmd(`GWP_CODE_PRE, 2'h0, 1'b1, 8'h00);
    settle();
    check(bopen, 4'h0);
endtask

initial begin
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    settle();
    t_reset();
    t_write();
    t_pre();
    t_pd(1'b1);
    t_pd(1'b0);
    end_of_test();
end
endmodule
